// *** design/rssl_defines.svh ***
/*
  constants for run set select and link supervision: command and status
  bit positions, parameter codes, timing figures.
  assumes a 20 MHz ref_clk.
*/
`ifndef RSSL_DEFINES_SVH
`define RSSL_DEFINES_SVH
`define RSSL_CLK_HZ 20000000
`define RSSL_CYC_PER_MS (`RSSL_CLK_HZ / 1000)
`define RSSL_CMD_MAN_UP 0
`define RSSL_CMD_MAN_DN 1
`define RSSL_CMD_POS 2
`define RSSL_CMD_STOP 3
`define RSSL_CMD_SET_LO 8
`define RSSL_CMD_SET_HI 9
`define RSSL_ST_MOVING 6
`define RSSL_ST_POSERR 10
`define RSSL_ST_LINKOK 11
`define RSSL_SAVE_CMD_VAL 8'hA1
`define RSSL_DELIV_SAVE_VAL 16'h0001
`define RSSL_IDX_STDCMD 8'h02
`define RSSL_IDX_DELIV 8'hC2
`define RSSL_IDX_TIMEOUT 8'hA2
`define RSSL_IDX_ABRT_SPD 8'h8F
`define RSSL_IDX_ABRT_TIME 8'h9A
`define RSSL_IDX_CUR_RUN 8'h94
`define RSSL_IDX_CUR_START 8'h93
`define RSSL_IDX_MAN_SPD 8'h8A
`define RSSL_IDX_POS_SPD 8'h89
`define RSSL_IDX_TSTART 8'h9B
`define RSSL_DEF_ABRT_PCT 16'h001E
`define RSSL_DEF_ABRT_MS 16'h00C8
`define RSSL_REF_CUR 16'h000A
`define RSSL_REF_ABRT_PCT 16'h003C
`define RSSL_REF_ABRT_MS 16'h0064
`define RSSL_BACKOFF_MS 16'h0032
`define RSSL_PCT_FULL 16'h0064
`endif

// *** design/rssl_pkg.sv ***
/*
  types for the run set link: run set and run state for the drive end, sequence state for the master end.
  assumes rssl_defines.svh for figures.
*/
package rssl_pkg;
  typedef struct packed {
    logic [15:0] posWin;
    logic [15:0] posSpeed;
    logic [15:0] manSpeed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] abortPct;
    logic [15:0] curStart;
    logic [15:0] curRun;
    logic [15:0] curHoldEnd;
    logic [15:0] curHold;
    logic [15:0] abortMs;
    logic [15:0] startMs;
    logic [15:0] holdEndMs;
  } rssl_set_t;
  typedef enum {RSSL_IDLE, RSSL_RUN, RSSL_STOPPED} rssl_run_t;
  typedef enum {RSSL_H_IDLE, RSSL_H_CFG, RSSL_H_FWD, RSSL_H_WAITMOVE, RSSL_H_WAITSTOP,
    RSSL_H_BACK, RSSL_H_BACKSTOP, RSSL_H_RESTORE, RSSL_H_DONE} rssl_host_t;
endpackage

// *** design/rssl_link_if.sv ***
/*
  process data and parameter link between master and drive.
  assumes one shared ref_clk.
*/
interface rssl_link_if;
  logic telegram;
  logic [15:0] command;
  logic paramWr;
  logic [7:0] paramIdx;
  logic [1:0] paramSub;
  logic [15:0] paramVal;
  logic [15:0] status;
  modport master (output telegram, output command, output paramWr, output paramIdx,
    output paramSub, output paramVal, input status);
  modport drive (input telegram, input command, input paramWr, input paramIdx,
    input paramSub, input paramVal, output status);
endinterface

// *** design/rssl_drive.sv ***
/*
  drive end: run set selection, link supervision, stall abort, save command.
  assumes link signals on ref_clk; speed feedback is a same-clock input.
*/
`include "rssl_defines.svh"

// Notes on behaviour
// (RULE1) command bits 9..8 select run set 1-4
// (RULE2) selected set parameters apply at once
// (RULE3) set change accepted during active run
// (RULE4) start-up current and time latch per run
// (RULE5) variants without changeover ignore bits 9..8
// (RULE6) timeout zero: finish run, block new; code never flags link loss then, so new runs are not blocked
// (RULE7) nonzero timeout: abort run, block new
// (RULE8) bit 6 moving; error stop sets bit 10
// (RULE9) bit 0/1 manual run at manual speed
// (RULE10) abort when slow too long; 30%/200ms default
// (RULE11) master lowers currents and abort limits first
// (RULE12) master backs off, then restores settings
// (RULE13) save only on 161 or delivery status 1
// (RULE14) master pushes no defaults after restart
// (RULE15) selector re-read every telegram
module rssl_drive #(
  parameter bit HAS_SET_SWITCH = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  rssl_link_if.drive link,
  input wire logic [15:0] actSpeed,
  input wire logic targetReached,
  output logic motorRun,
  output logic motorDirDn,
  output logic [15:0] motorSpeed,
  output logic [15:0] motorCurLimit,
  output rssl_pkg::rssl_set_t activeSet,
  output logic saveNv
);
  // ----------------------------------------
  // parameter storage
  // ----------------------------------------
  rssl_pkg::rssl_set_t sets_q [4];
  rssl_pkg::rssl_set_t sets_d [4];
  logic [15:0] timeoutMs_q, timeoutMs_d;
  logic [1:0] sel_q, sel_d;
  logic saveNv_d;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sets_d[i] = sets_q[i];
    end
    timeoutMs_d = timeoutMs_q;
    sel_d = sel_q;
    saveNv_d = 1'b0;
    if (link.telegram && HAS_SET_SWITCH) begin // RULE5
      sel_d = link.command[`RSSL_CMD_SET_HI:`RSSL_CMD_SET_LO]; // RULE1 RULE3 RULE15
    end
    if (link.paramWr) begin
      unique case (link.paramIdx)
        `RSSL_IDX_STDCMD: saveNv_d = (link.paramVal[7:0] == `RSSL_SAVE_CMD_VAL); // RULE13
        `RSSL_IDX_DELIV: saveNv_d = (link.paramVal == `RSSL_DELIV_SAVE_VAL); // RULE13
        `RSSL_IDX_TIMEOUT: timeoutMs_d = link.paramVal;
        `RSSL_IDX_ABRT_SPD: sets_d[link.paramSub].abortPct = link.paramVal;
        `RSSL_IDX_ABRT_TIME: sets_d[link.paramSub].abortMs = link.paramVal;
        `RSSL_IDX_CUR_RUN: sets_d[link.paramSub].curRun = link.paramVal;
        `RSSL_IDX_CUR_START: sets_d[link.paramSub].curStart = link.paramVal;
        `RSSL_IDX_MAN_SPD: sets_d[link.paramSub].manSpeed = link.paramVal;
        `RSSL_IDX_POS_SPD: sets_d[link.paramSub].posSpeed = link.paramVal;
        `RSSL_IDX_TSTART: sets_d[link.paramSub].startMs = link.paramVal;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        sets_q[i] <= '0;
        sets_q[i].abortPct <= `RSSL_DEF_ABRT_PCT;
        sets_q[i].abortMs <= `RSSL_DEF_ABRT_MS;
      end
      timeoutMs_q <= '0;
      sel_q <= '0;
      saveNv <= 1'b0;
    end else if (clkEn) begin
      sets_q <= sets_d;
      timeoutMs_q <= timeoutMs_d;
      sel_q <= sel_d;
      saveNv <= saveNv_d;
    end
  end

  // ----------------------------------------
  // link supervision
  // ----------------------------------------
  logic [15:0] msCnt_q, msCnt_d;
  logic [14:0] cyc_q, cyc_d;
  logic linkOk_q, linkOk_d;
  logic linkLost_q, linkLost_d;

  always_comb begin
    cyc_d = cyc_q;
    msCnt_d = msCnt_q;
    linkOk_d = linkOk_q;
    linkLost_d = 1'b0;
    if (link.telegram) begin
      cyc_d = '0;
      msCnt_d = '0;
      linkOk_d = 1'b1;
    end else if (linkOk_q && timeoutMs_q != '0) begin // RULE7
      if (cyc_q == 15'(`RSSL_CYC_PER_MS - 1)) begin
        cyc_d = '0;
        msCnt_d = msCnt_q + 16'h0001;
        if (msCnt_q + 16'h0001 >= timeoutMs_q) begin
          linkOk_d = 1'b0;
          linkLost_d = 1'b1;
        end
      end else begin
        cyc_d = cyc_q + 15'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cyc_q <= '0;
      msCnt_q <= '0;
      linkOk_q <= 1'b0;
      linkLost_q <= 1'b0;
    end else if (clkEn) begin
      cyc_q <= cyc_d;
      msCnt_q <= msCnt_d;
      linkOk_q <= linkOk_d;
      linkLost_q <= linkLost_d;
    end
  end

  // ----------------------------------------
  // run control and stall abort
  // ----------------------------------------
  rssl_pkg::rssl_run_t run_q, run_d;
  logic manual_q, manual_d;
  logic dirDn_q, dirDn_d;
  logic [15:0] startCur_q, startCur_d;
  logic [31:0] startCyc_q, startCyc_d;
  logic [31:0] slowCyc_q, slowCyc_d;
  logic posErr_q, posErr_d;
  rssl_pkg::rssl_set_t cur;
  rssl_pkg::rssl_set_t nxt;
  logic [15:0] tgtSpeed;
  logic startReq;
  logic slow;

  always_comb begin
    cur = sets_q[sel_q]; // RULE2
    nxt = sets_q[sel_d];
    tgtSpeed = manual_q ? cur.manSpeed : cur.posSpeed; // RULE9
    slow = (32'(actSpeed) * 32'(`RSSL_PCT_FULL)) < (32'(tgtSpeed) * 32'(cur.abortPct));
    startReq = link.telegram && linkOk_q && (link.command[`RSSL_CMD_MAN_UP]
      || link.command[`RSSL_CMD_MAN_DN] || link.command[`RSSL_CMD_POS]); // RULE6 RULE7
    run_d = run_q;
    manual_d = manual_q;
    dirDn_d = dirDn_q;
    startCur_d = startCur_q;
    startCyc_d = startCyc_q;
    slowCyc_d = slowCyc_q;
    posErr_d = posErr_q;
    unique case (run_q)
      rssl_pkg::RSSL_IDLE, rssl_pkg::RSSL_STOPPED: begin
        if (startReq) begin
          run_d = rssl_pkg::RSSL_RUN;
          manual_d = link.command[`RSSL_CMD_MAN_UP] || link.command[`RSSL_CMD_MAN_DN]; // RULE9
          dirDn_d = link.command[`RSSL_CMD_MAN_DN];
          startCur_d = nxt.curStart; // RULE4
          startCyc_d = 32'(nxt.startMs) * 32'(`RSSL_CYC_PER_MS); // RULE4
          slowCyc_d = '0;
          posErr_d = 1'b0;
        end
      end
      rssl_pkg::RSSL_RUN: begin
        if (startCyc_q != '0) begin
          startCyc_d = startCyc_q - 32'h0000_0001;
        end
        slowCyc_d = slow ? slowCyc_q + 32'h0000_0001 : '0;
        if (linkLost_q) begin
          run_d = rssl_pkg::RSSL_STOPPED; // RULE7
        end else if (link.telegram && link.command[`RSSL_CMD_STOP]) begin
          run_d = rssl_pkg::RSSL_STOPPED;
        end else if (slow && slowCyc_q > 32'(cur.abortMs) * 32'(`RSSL_CYC_PER_MS)) begin
          run_d = rssl_pkg::RSSL_STOPPED; // RULE10
          posErr_d = 1'b1; // RULE8
        end else if (targetReached && !manual_q) begin
          run_d = rssl_pkg::RSSL_IDLE; // RULE6
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_q <= rssl_pkg::RSSL_IDLE;
      manual_q <= 1'b0;
      dirDn_q <= 1'b0;
      startCur_q <= '0;
      startCyc_q <= '0;
      slowCyc_q <= '0;
      posErr_q <= 1'b0;
      motorRun <= 1'b0;
      motorDirDn <= 1'b0;
      motorSpeed <= '0;
      motorCurLimit <= '0;
      activeSet <= '0;
      link.status <= '0;
    end else if (clkEn) begin
      run_q <= run_d;
      manual_q <= manual_d;
      dirDn_q <= dirDn_d;
      startCur_q <= startCur_d;
      startCyc_q <= startCyc_d;
      slowCyc_q <= slowCyc_d;
      posErr_q <= posErr_d;
      motorRun <= (run_d == rssl_pkg::RSSL_RUN);
      motorDirDn <= dirDn_d;
      motorSpeed <= tgtSpeed; // RULE2
      motorCurLimit <= (run_d == rssl_pkg::RSSL_RUN && startCyc_d != '0) ? startCur_d
        : cur.curRun; // RULE4
      activeSet <= cur;
      link.status <= '0;
      link.status[`RSSL_ST_MOVING] <= (run_d == rssl_pkg::RSSL_RUN); // RULE8
      link.status[`RSSL_ST_POSERR] <= posErr_d; // RULE8
      link.status[`RSSL_ST_LINKOK] <= linkOk_d;
    end
  end
endmodule

// *** design/rssl_master.sv ***
/*
  master end: drives process data and parameter writes, runs the stall
  reference sequence on request. assumes rssl_link_if on the same clock.
*/
`include "rssl_defines.svh"

module rssl_master (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  rssl_link_if.master link,
  input wire logic userTelegram,
  input wire logic [15:0] userCommand,
  input wire logic userParamWr,
  input wire logic [7:0] userParamIdx,
  input wire logic [1:0] userParamSub,
  input wire logic [15:0] userParamVal,
  input wire logic refStart,
  input wire logic refDirDn,
  output logic refBusy,
  output logic [15:0] driveStatus
);
  // ----------------------------------------
  // reference sequence
  // ----------------------------------------
  rssl_pkg::rssl_host_t st_q, st_d;
  logic [3:0] step_q, step_d;
  logic [19:0] wait_q, wait_d;
  logic tel_d, wr_d;
  logic [15:0] cmd_d, val_d;
  logic [7:0] idx_d;
  logic [1:0] sub_d;
  logic [1:0] setSel;
  logic moving;

  always_comb begin
    setSel = userCommand[`RSSL_CMD_SET_HI:`RSSL_CMD_SET_LO];
    moving = link.status[`RSSL_ST_MOVING];
    st_d = st_q;
    step_d = step_q;
    wait_d = wait_q;
    tel_d = userTelegram;
    cmd_d = userCommand;
    wr_d = userParamWr; // RULE14
    idx_d = userParamIdx;
    sub_d = userParamSub;
    val_d = userParamVal;
    if (st_q != rssl_pkg::RSSL_H_IDLE) begin
      tel_d = 1'b1;
      cmd_d = '0;
      cmd_d[`RSSL_CMD_SET_HI:`RSSL_CMD_SET_LO] = setSel;
      wr_d = 1'b0;
      sub_d = setSel;
      idx_d = '0;
      val_d = '0;
    end
    unique case (st_q)
      rssl_pkg::RSSL_H_IDLE: if (refStart) begin
        st_d = rssl_pkg::RSSL_H_CFG;
        step_d = '0;
      end
      rssl_pkg::RSSL_H_CFG, rssl_pkg::RSSL_H_RESTORE: begin
        wr_d = 1'b1;
        unique case (step_q)
          4'h0: begin idx_d = `RSSL_IDX_CUR_RUN; val_d = `RSSL_REF_CUR; end // RULE11
          4'h1: begin idx_d = `RSSL_IDX_CUR_START; val_d = `RSSL_REF_CUR; end // RULE11
          4'h2: begin idx_d = `RSSL_IDX_ABRT_SPD; val_d = `RSSL_REF_ABRT_PCT; end // RULE11
          default: begin idx_d = `RSSL_IDX_ABRT_TIME; val_d = `RSSL_REF_ABRT_MS; end // RULE11
        endcase
        if (st_q == rssl_pkg::RSSL_H_RESTORE) begin
          val_d = userParamVal; // RULE12
          idx_d = userParamIdx;
        end
        step_d = step_q + 4'h1;
        if (step_q == 4'h3) begin
          st_d = (st_q == rssl_pkg::RSSL_H_CFG) ? rssl_pkg::RSSL_H_FWD : rssl_pkg::RSSL_H_DONE;
        end
      end
      rssl_pkg::RSSL_H_FWD: begin
        cmd_d[refDirDn ? `RSSL_CMD_MAN_DN : `RSSL_CMD_MAN_UP] = 1'b1; // RULE9
        st_d = rssl_pkg::RSSL_H_WAITMOVE;
      end
      rssl_pkg::RSSL_H_WAITMOVE: if (moving) begin
        st_d = rssl_pkg::RSSL_H_WAITSTOP;
      end
      rssl_pkg::RSSL_H_WAITSTOP: if (!moving && link.status[`RSSL_ST_POSERR]) begin
        st_d = rssl_pkg::RSSL_H_BACK;
        wait_d = 20'(32'(`RSSL_BACKOFF_MS) * 32'(`RSSL_CYC_PER_MS));
      end
      rssl_pkg::RSSL_H_BACK: begin
        cmd_d[refDirDn ? `RSSL_CMD_MAN_UP : `RSSL_CMD_MAN_DN] = 1'b1; // RULE12
        wait_d = wait_q - 20'h00001;
        if (wait_q == '0) begin
          st_d = rssl_pkg::RSSL_H_BACKSTOP;
        end
      end
      rssl_pkg::RSSL_H_BACKSTOP: begin
        cmd_d[`RSSL_CMD_STOP] = 1'b1;
        if (!moving) begin
          st_d = rssl_pkg::RSSL_H_RESTORE;
          step_d = '0;
        end
      end
      rssl_pkg::RSSL_H_DONE: st_d = rssl_pkg::RSSL_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= rssl_pkg::RSSL_H_IDLE;
      step_q <= '0;
      wait_q <= '0;
      link.telegram <= 1'b0;
      link.command <= '0;
      link.paramWr <= 1'b0;
      link.paramIdx <= '0;
      link.paramSub <= '0;
      link.paramVal <= '0;
      refBusy <= 1'b0;
      driveStatus <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
      step_q <= step_d;
      wait_q <= wait_d;
      link.telegram <= tel_d;
      link.command <= cmd_d;
      link.paramWr <= wr_d;
      link.paramIdx <= idx_d;
      link.paramSub <= sub_d;
      link.paramVal <= val_d;
      refBusy <= (st_d != rssl_pkg::RSSL_H_IDLE);
      driveStatus <= link.status;
    end
  end
endmodule

// *** testbench/rssl_link_checker.sv ***
/*
  checker on the run set link: status timing against telegrams and writes.
  assumes one ref_clk and a synchronous active-high reset.
*/
module rssl_link_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic telegram,
  input wire logic [15:0] command,
  input wire logic paramWr,
  input wire logic [15:0] status
);
  // ------------
  // helpers
  // ------------
  int unsigned moveCnt_q;
  int unsigned moveCnt_d;
  always_comb moveCnt_d = status[6] ? moveCnt_q + 1 : 0;
  always_ff @(posedge ref_clk) moveCnt_q <= reset ? 0 : moveCnt_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ------------
  // assertions
  // ------------
  link_up_a: assert property (telegram |-> ##2 status[11])
    else $error("link ok missing after telegram");
  start_link_a: assert property ($rose(status[6]) |-> status[11])
    else $error("run started without link");
  man_start_a: assert property (telegram && ^command[1:0] && !command[3]
      && status[11] && !status[6] && !status[10] |-> ##[1:3] status[6])
    else $error("manual run did not start");
  err_move_a: assert property ($rose(status[10]) |-> !status[6])
    else $error("moving still set with error");
  err_prior_a: assert property ($rose(status[10]) |-> $past(status[6]))
    else $error("error without a run");
  loss_abort_a: assert property ($fell(status[11]) |-> ##[0:2] !status[6])
    else $error("run kept after link loss");
  stall_time_a: assert property ($rose(status[10]) |-> moveCnt_q >= 19990)
    else $error("stall abort too early");
  no_push_a: assert property ($fell(reset) |-> !paramWr [*4])
    else $error("parameter write right after reset");
  cover property ($rose(status[6]));
  cover property ($rose(status[10]));
  cover property ($fell(status[11]));
  cover property (paramWr && telegram);
endmodule

// *** testbench/test_run_set_select_link_supervision.sv ***
/*
  testbench: master and drive joined by the link, user side driven here.
  assumes design files compiled first and rssl_defines.svh on the path.
*/
`include "rssl_defines.svh"

module test_run_set_select_link_supervision;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] sel; logic [15:0] spd;} rssl_row_t;
  rssl_row_t rows [4] = '{'{2'h0, 16'h0100}, '{2'h1, 16'h0101}, '{2'h2, 16'h0102},
    '{2'h3, 16'h0103}};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic userTelegram = 1'b0;
  logic [15:0] userCommand = 16'h0000;
  logic userParamWr = 1'b0;
  logic [7:0] userParamIdx = 8'h00;
  logic [1:0] userParamSub = 2'h0;
  logic [15:0] userParamVal = 16'h0000;
  logic [15:0] actSpeed = 16'h0200;
  logic targetReached = 1'b0;
  logic clkEn = 1'b1;
  logic refStart = 1'b0;
  logic refDirDn = 1'b0;
  logic refBusy, motorRun, motorDirDn, saveNv;
  logic [15:0] driveStatus, motorSpeed, motorCurLimit;
  rssl_pkg::rssl_set_t activeSet, activeSetB;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int saves = 0;
  int n;
  rssl_link_if link();
  rssl_link_if linkB();
  assign linkB.telegram = link.telegram;
  assign linkB.command = link.command;
  assign linkB.paramWr = link.paramWr;
  assign linkB.paramIdx = link.paramIdx;
  assign linkB.paramSub = link.paramSub;
  assign linkB.paramVal = link.paramVal;
  rssl_master rssl_master_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .link(link),
    .userTelegram(userTelegram), .userCommand(userCommand), .userParamWr(userParamWr),
    .userParamIdx(userParamIdx), .userParamSub(userParamSub), .userParamVal(userParamVal),
    .refStart(refStart), .refDirDn(refDirDn), .refBusy(refBusy), .driveStatus(driveStatus));
  rssl_drive rssl_drive_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .link(link),
    .actSpeed(actSpeed), .targetReached(targetReached), .motorRun(motorRun),
    .motorDirDn(motorDirDn), .motorSpeed(motorSpeed), .motorCurLimit(motorCurLimit),
    .activeSet(activeSet), .saveNv(saveNv));
  rssl_drive #(.HAS_SET_SWITCH(1'b0)) rssl_drive_fixed_inst (.ref_clk(ref_clk), .reset(reset),
    .clkEn(clkEn), .link(linkB), .actSpeed(actSpeed), .targetReached(targetReached),
    .motorRun(), .motorDirDn(), .motorSpeed(), .motorCurLimit(), .activeSet(activeSetB),
    .saveNv());
  rssl_link_checker rssl_link_checker_inst (.ref_clk(ref_clk), .reset(reset),
    .telegram(link.telegram), .command(link.command), .paramWr(link.paramWr),
    .status(link.status));
  // ------------
  // clock, watchdog, tasks
  // ------------
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (saveNv === 1'b1) saves <= saves + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #5;
  endtask
  task automatic tele(input logic [15:0] cmd);
    userCommand = cmd;
    userTelegram = 1'b1;
    tick(1);
    userTelegram = 1'b0;
    tick(3);
  endtask
  task automatic par(input logic [7:0] idx, input logic [1:0] sub, input logic [15:0] val);
    userParamIdx = idx;
    userParamSub = sub;
    userParamVal = val;
    userParamWr = 1'b1;
    tick(1);
    userParamWr = 1'b0;
    tick(3);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitbit(input int b, input logic v, output int k);
    k = 0;
    while (driveStatus[b] !== v && k < 21000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------
  // tests
  // ------------
  initial begin
    tick(16);
    reset = 1'b0;
    tick(4);
    cmp(driveStatus, 16'h0000);
    cmp(activeSet.abortPct, `RSSL_DEF_ABRT_PCT);
    cmp(activeSet.abortMs, `RSSL_DEF_ABRT_MS);
    done("reset");
    for (int s = 0; s < 4; s++) par(`RSSL_IDX_MAN_SPD, 2'(s), 16'h0100 + 16'(s));
    tele(16'h0000);
    foreach (rows[i]) begin
      tele({6'h00, rows[i].sel, 8'h00});
      cmp(activeSet.manSpeed, rows[i].spd);
      cmp(activeSetB.manSpeed, 16'h0100);
    end
    done("rows");
    tele(16'h0101);
    cmp({15'h0000, motorRun}, 16'h0001);
    cmp(motorSpeed, 16'h0101);
    tele(16'h0301);
    cmp(motorSpeed, 16'h0103);
    cmp({15'h0000, motorRun}, 16'h0001);
    par(`RSSL_IDX_ABRT_TIME, 2'h3, 16'h0001);
    actSpeed = 16'h0000;
    waitbit(10, 1'b1, n);
    cmp({15'h0000, n >= 19990 && n < 21000}, 16'h0001);
    cmp({15'h0000, driveStatus[6]}, 16'h0000);
    done("stall");
    actSpeed = 16'h0200;
    tele(16'h0308);
    par(`RSSL_IDX_TIMEOUT, 2'h0, 16'h0001);
    tele(16'h0302);
    cmp({15'h0000, motorDirDn}, 16'h0001);
    waitbit(11, 1'b0, n);
    tick(2);
    cmp({15'h0000, motorRun}, 16'h0000);
    tele(16'h0302);
    cmp({15'h0000, motorRun}, 16'h0000);
    tele(16'h0302);
    cmp({15'h0000, motorRun}, 16'h0001);
    done("timeout");
    tele(16'h0308);
    par(`RSSL_IDX_TIMEOUT, 2'h0, 16'h0000);
    tele(16'h0304);
    tick(22000);
    cmp({15'h0000, motorRun}, 16'h0001);
    clkEn = 1'b0;
    targetReached = 1'b1;
    tick(3);
    cmp({15'h0000, motorRun}, 16'h0001);
    clkEn = 1'b1;
    tick(3);
    cmp({15'h0000, driveStatus[6]}, 16'h0000);
    targetReached = 1'b0;
    done("finish");
    par(`RSSL_IDX_TSTART, 2'h0, 16'h0001);
    par(`RSSL_IDX_CUR_START, 2'h0, 16'h0011);
    par(`RSSL_IDX_CUR_START, 2'h1, 16'h0022);
    tele(16'h0004);
    cmp(motorCurLimit, 16'h0011);
    tele(16'h0104);
    cmp(motorCurLimit, 16'h0011);
    cmp(activeSet.curStart, 16'h0022);
    tele(16'h0108);
    cmp({15'h0000, motorRun}, 16'h0000);
    done("startcur");
    cmp(saves[15:0], 16'h0000);
    par(`RSSL_IDX_STDCMD, 2'h0, 16'h00A1);
    cmp(saves[15:0], 16'h0001);
    par(`RSSL_IDX_STDCMD, 2'h0, 16'h00A0);
    par(`RSSL_IDX_DELIV, 2'h0, 16'h0001);
    par(`RSSL_IDX_DELIV, 2'h0, 16'h0002);
    cmp(saves[15:0], 16'h0002);
    done("save");
    userCommand = 16'h0200;
    refDirDn = 1'b1;
    refStart = 1'b1;
    tick(1);
    refStart = 1'b0;
    tick(12);
    cmp({15'h0000, refBusy}, 16'h0001);
    cmp(activeSet.curRun, `RSSL_REF_CUR);
    cmp(activeSet.curStart, `RSSL_REF_CUR);
    cmp(activeSet.abortPct, `RSSL_REF_ABRT_PCT);
    cmp(activeSet.abortMs, `RSSL_REF_ABRT_MS);
    cmp(motorCurLimit, `RSSL_REF_CUR);
    cmp({15'h0000, motorRun}, 16'h0001);
    cmp({15'h0000, motorDirDn}, 16'h0001);
    cmp(motorSpeed, 16'h0102);
    done("reference");
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    cmp({15'h0000, motorRun}, 16'h0000);
    cmp({15'h0000, refBusy}, 16'h0000);
    cmp(driveStatus, 16'h0000);
    done("midreset");
    results();
  end
endmodule
